// File: rtl/scs_pkg.sv
// Constants shared by the simulator command and clock logic
`default_nettype none
package scs_pkg;
	localparam int unsigned CLK_HZ           = 250_000_000;
	localparam int unsigned CMD_PULSE_MS     = 30;
	localparam int unsigned MASTER_PERIOD_MS = 640;
	localparam int unsigned DEBOUNCE_MS      = 5;
	localparam int unsigned STAGE_DELAY_NS   = 1000;
	localparam int unsigned CMD_PULSE_CYC    = (CLK_HZ / 1000) * CMD_PULSE_MS;
	localparam int unsigned MASTER_CYC       = (CLK_HZ / 1000) * MASTER_PERIOD_MS;
	localparam int unsigned DEBOUNCE_CYC     = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned STAGE_DELAY_CYC  =
		((CLK_HZ / 1_000_000) * STAGE_DELAY_NS + 999) / 1000;
	localparam int unsigned DIV_STAGES       = 9;
	localparam int unsigned CAL_LSB          = 6;
	localparam int unsigned CMD_LINES        = 8;
	localparam int unsigned SEL_W            = 3;
	localparam logic [11:0] OFS_CTRL         = 12'h000;
	localparam logic [11:0] OFS_STATUS       = 12'h004;
	localparam logic [11:0] OFS_SELECT       = 12'h008;
	localparam int unsigned CTRL_ARM_BIT     = 0;
	localparam int unsigned CTRL_CMD_BIT     = 1;
	localparam int unsigned CTRL_RUN_BIT     = 2;
	localparam logic        CTRL_RUN_RESET   = 1'b1;
	localparam int unsigned ST_LOCK_BIT      = 0;
	localparam int unsigned ST_DONE_BIT      = 1;
	localparam int unsigned ST_PULSE_BIT     = 2;
	localparam int unsigned ST_ELEC_BIT      = 3;
	localparam int unsigned ST_CAL_BIT       = 4;
	localparam int unsigned ST_COUNT_LSB     = 8;
	localparam int unsigned SELRD_LIVE_LSB   = 0;
	localparam int unsigned SELRD_HELD_LSB   = 4;
	typedef enum logic [1:0] {
		SCS_ARMED = 2'b00,
		SCS_PULSE = 2'b01,
		SCS_DONE  = 2'b11
	} scs_state_t;
endpackage : scs_pkg
`default_nettype wire

// File: rtl/scs_if.sv
// Carriers between the top and its debounce and clock chain modules
`default_nettype none
interface scs_panel_if;
	logic                      arm_level;
	logic                      cmd_level;
	logic                      elec_level;
	logic [scs_pkg::SEL_W-1:0] sel_level;
	modport src (output arm_level, cmd_level, elec_level, sel_level);
	modport dst (input arm_level, cmd_level, elec_level, sel_level);
endinterface : scs_panel_if

interface scs_chain_if;
	logic                           run;
	logic [scs_pkg::DIV_STAGES-1:0] stage;
	logic                           cal;
	modport src (input run, output stage, cal);
	modport dst (output run, input stage, cal);
endinterface : scs_chain_if
`default_nettype wire

// File: rtl/scs_debounce.sv
// Synchroniser and sampling debouncer for the panel switches
`default_nettype none
module scs_debounce
	import scs_pkg::*;
#(
	parameter int unsigned DEB_CYC = scs_pkg::DEBOUNCE_CYC
) (
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic                      arm_pin,
	input  wire logic                      cmd_pin,
	input  wire logic                      elec_pin,
	input  wire logic [scs_pkg::SEL_W-1:0] sel_pin,
	scs_panel_if.src                       panel
);
	localparam int unsigned N  = 3 + SEL_W;
	localparam int unsigned CW = (DEB_CYC > 1) ? $clog2(DEB_CYC) : 1;
	if (DEB_CYC < 1) begin : g_chk
		$error("scs_debounce: DEB_CYC must be at least one");
	end
	logic [N-1:0]  meta_reg, sync_reg, samp_reg, out_reg;
	logic [N-1:0]  samp_next, out_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic          tick;
	// Bounce shorter than one sample period never reaches the output
	always_comb begin
		tick      = (cnt_reg == CW'(DEB_CYC - 1));
		cnt_next  = tick ? '0 : cnt_reg + CW'(1);
		samp_next = tick ? sync_reg : samp_reg;
		out_next  = out_reg;
		if (tick) begin
			out_next = (sync_reg == samp_reg) ? sync_reg : out_reg;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
			samp_reg <= '0;
			out_reg  <= '0;
			cnt_reg  <= '0;
		end else begin
			meta_reg <= {sel_pin, elec_pin, cmd_pin, arm_pin};
			sync_reg <= meta_reg;
			samp_reg <= samp_next;
			out_reg  <= out_next;
			cnt_reg  <= cnt_next;
		end
	end
	assign panel.arm_level  = out_reg[0];
	assign panel.cmd_level  = out_reg[1];
	assign panel.elec_level = out_reg[2];
	assign panel.sel_level  = out_reg[N-1:3];
endmodule : scs_debounce
`default_nettype wire

// File: rtl/scs_clock_chain.sv
// Master clock, nine divide-by-two stages and staggered timing edges
`default_nettype none
module scs_clock_chain
	import scs_pkg::*;
#(
	parameter int unsigned MASTER_CYC_P = scs_pkg::MASTER_CYC,
	parameter int unsigned DELAY_CYC_P  = scs_pkg::STAGE_DELAY_CYC
) (
	input  wire logic clock,
	input  wire logic reset,
	scs_chain_if.src  chain
);
	localparam int unsigned MW = (MASTER_CYC_P > 1) ? $clog2(MASTER_CYC_P) : 1;
	localparam int unsigned SPAN = DELAY_CYC_P * DIV_STAGES;
	localparam int unsigned DW = $clog2(SPAN + 2);
	if (MASTER_CYC_P <= SPAN + 1 || DELAY_CYC_P < 1) begin : g_chk
		$error("scs_clock_chain: stagger must fit inside one master period");
	end
	logic [MW-1:0]         pre_reg, pre_next;
	logic [DIV_STAGES-1:0] cnt_reg, cnt_next, out_reg, out_next;
	logic [DW-1:0]         dly_reg, dly_next;
	logic                  cal_reg, cal_next;
	logic                  tick;
	always_comb begin
		tick     = chain.run && (pre_reg == MW'(MASTER_CYC_P - 1));
		pre_next = chain.run ? (tick ? '0 : pre_reg + MW'(1)) : pre_reg;
		cnt_next = tick ? cnt_reg + DIV_STAGES'(1) : cnt_reg;
		dly_next = tick ? DW'(1) : (dly_reg != '0 ? dly_reg + DW'(1) : dly_reg);
		if (dly_reg == DW'(SPAN + 1)) begin
			dly_next = '0;
		end
		out_next = out_reg;
		cal_next = cal_reg;
		// One stage follows another by a fixed gap, like slow cable edges
		for (int k = 0; k < DIV_STAGES; k++) begin
			if (dly_reg == DW'(DELAY_CYC_P * (k + 1))) begin
				out_next[k] = cnt_reg[k];
			end
		end
		if (dly_reg == DW'(SPAN + 1)) begin
			cal_next = &cnt_reg[DIV_STAGES-1:CAL_LSB];
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pre_reg <= '0;
			cnt_reg <= '0;
			out_reg <= '0;
			dly_reg <= '0;
			cal_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			dly_reg <= dly_next;
			cal_reg <= cal_next;
		end
	end
	assign chain.stage = out_reg;
	assign chain.cal   = cal_reg;
endmodule : scs_clock_chain
`default_nettype wire

// File: rtl/scs_command_sim.sv
// Top: impulse command sequencer, level command, timing outputs, APB slave
//
// Overview of operation
// - Pulse only the selected line for 30 ms
// - Reset press outside a pulse clears both flops, arming
// - Armed: reset lamp on, command lamp off
// - Armed press sets lockout, starts one-shot
// - One-shot drives relay, routed to line
// - Relay dropout sets completion, lights lamp
// - One pulse per reset-command sequence only
// - 0.64 s master clock, nine dividers
// - Calibration 40.96 s every 5.46 minutes
// - Stagger successive timing output edges
// - Switch drives steady electronics on level
`default_nettype none
module scs_command_sim
	import scs_pkg::*;
#(
	parameter int unsigned PULSE_CYC    = scs_pkg::CMD_PULSE_CYC,
	parameter int unsigned MASTER_CYC_P = scs_pkg::MASTER_CYC,
	parameter int unsigned DEB_CYC      = scs_pkg::DEBOUNCE_CYC,
	parameter int unsigned DELAY_CYC_P  = scs_pkg::STAGE_DELAY_CYC
) (
	input  wire logic                           clock,
	input  wire logic                           reset,
	input  wire logic                           arm_button,
	input  wire logic                           command_button,
	input  wire logic                           electronics_switch,
	input  wire logic [scs_pkg::SEL_W-1:0]      command_select,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [11:0]                    paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	output logic      [scs_pkg::CMD_LINES-1:0]  command_line,
	output logic                                command_relay,
	output logic                                reset_lamp,
	output logic                                command_lamp,
	output logic                                electronics_on,
	output logic      [scs_pkg::DIV_STAGES-1:0] timing_out,
	output logic                                cal_clock
);
	localparam int unsigned PW = (PULSE_CYC > 1) ? $clog2(PULSE_CYC) : 1;
	if (PULSE_CYC < 1 || (1 << SEL_W) > CMD_LINES) begin : g_chk
		$error("scs_command_sim: pulse length or select width not servable");
	end

	function automatic logic [CMD_LINES-1:0] line_decode(
		input logic [SEL_W-1:0] sel
	);
		logic [CMD_LINES-1:0] v;
		v = '0;
		v[sel] = 1'b1;
		return v;
	endfunction : line_decode

	function automatic logic reg_hit(
		input logic [11:0] a
	);
		return (a == OFS_CTRL) ||
			(a == OFS_STATUS) ||
			(a == OFS_SELECT);
	endfunction : reg_hit

	scs_panel_if panel ();
	scs_chain_if chain ();

	scs_debounce #(
		.DEB_CYC (DEB_CYC)
	) u_debounce (
		.clock    (clock),
		.reset    (reset),
		.arm_pin  (arm_button),
		.cmd_pin  (command_button),
		.elec_pin (electronics_switch),
		.sel_pin  (command_select),
		.panel    (panel)
	);

	scs_clock_chain #(
		.MASTER_CYC_P (MASTER_CYC_P),
		.DELAY_CYC_P  (DELAY_CYC_P)
	) u_chain (
		.clock (clock),
		.reset (reset),
		.chain (chain)
	);

	// Panel edge detection
	// Buttons idle low, so clearing to low makes no false edge
	logic arm_prev_reg, cmd_prev_reg;
	logic arm_edge, cmd_edge;
	always_comb begin
		arm_edge = panel.arm_level && !arm_prev_reg;
		cmd_edge = panel.cmd_level && !cmd_prev_reg;
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			arm_prev_reg <= 1'b0;
			cmd_prev_reg <= 1'b0;
		end else begin
			arm_prev_reg <= panel.arm_level;
			cmd_prev_reg <= panel.cmd_level;
		end
	end

	// APB register file
	logic            run_reg, run_next;
	logic            soft_arm_reg, soft_arm_next;
	logic            soft_cmd_reg, soft_cmd_next;
	logic            pready_reg, pready_next;
	logic            pslverr_reg, pslverr_next;
	logic [31:0]     prdata_reg, prdata_next;
	logic            bus_write;
	logic            mapped;

	// Sequencer state
	scs_state_t      state_reg, state_next;
	logic            lock_reg, lock_next;
	logic            done_reg, done_next;
	logic [PW-1:0]   shot_reg, shot_next;
	logic [SEL_W-1:0] held_sel_reg, held_sel_next;

	// Output flops
	logic [CMD_LINES-1:0] line_reg, line_next;
	logic            relay_reg, relay_next;
	logic            rlamp_reg, rlamp_next;
	logic            clamp_reg, clamp_next;
	logic            elec_reg, elec_next;
	logic [DIV_STAGES-1:0] tout_reg;
	logic            cal_reg;
	logic            arm_req, cmd_req;

	// Each access answers in its first access-phase cycle
	always_comb begin
		mapped = reg_hit(paddr);
		bus_write = psel && penable && pready_reg && pwrite && mapped;
		pready_next  = psel && !penable && !pready_reg;
		pslverr_next = psel && !penable && !mapped;
		prdata_next  = prdata_reg;
		// Read data stands only in the answering cycle
		if (pready_reg) begin
			prdata_next = '0;
		end
		run_next      = run_reg;
		soft_arm_next = 1'b0;
		soft_cmd_next = 1'b0;
		if (bus_write && paddr == OFS_CTRL) begin
			run_next      = pwdata[CTRL_RUN_BIT];
			soft_arm_next = pwdata[CTRL_ARM_BIT];
			soft_cmd_next = pwdata[CTRL_CMD_BIT];
		end
		if (psel && !penable) begin
			prdata_next = '0;
			if (!pwrite) begin
				unique case (paddr)
					OFS_CTRL: begin
						prdata_next[CTRL_RUN_BIT] = run_reg;
					end
					OFS_STATUS: begin
						prdata_next[ST_LOCK_BIT]  = lock_reg;
						prdata_next[ST_DONE_BIT]  = done_reg;
						prdata_next[ST_PULSE_BIT] = relay_reg;
						prdata_next[ST_ELEC_BIT]  = elec_reg;
						prdata_next[ST_CAL_BIT]   = cal_reg;
						prdata_next[ST_COUNT_LSB +: DIV_STAGES] = tout_reg;
					end
					OFS_SELECT: begin
						prdata_next[SELRD_LIVE_LSB +: SEL_W] = panel.sel_level;
						prdata_next[SELRD_HELD_LSB +: SEL_W] = held_sel_reg;
					end
					default: begin
						prdata_next = '0;
					end
				endcase
			end
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			run_reg      <= CTRL_RUN_RESET;
			soft_arm_reg <= 1'b0;
			soft_cmd_reg <= 1'b0;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			prdata_reg   <= '0;
		end else begin
			run_reg      <= run_next;
			soft_arm_reg <= soft_arm_next;
			soft_cmd_reg <= soft_cmd_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			prdata_reg   <= prdata_next;
		end
	end

	// Impulse command sequencer
	always_comb begin
		arm_req       = arm_edge || soft_arm_reg;
		cmd_req       = cmd_edge || soft_cmd_reg;
		state_next    = state_reg;
		lock_next     = lock_reg;
		done_next     = done_reg;
		shot_next     = shot_reg;
		held_sel_next = held_sel_reg;
		unique case (state_reg)
			SCS_ARMED: begin
				if (cmd_req) begin
					state_next    = SCS_PULSE;
					lock_next     = 1'b1;
					shot_next     = PW'(PULSE_CYC - 1);
					held_sel_next = panel.sel_level;
				end
			end
			SCS_PULSE: begin
				// A reset press mid-pulse is not honoured: the pulse runs out
				if (shot_reg == '0) begin
					state_next = SCS_DONE;
					done_next  = 1'b1;
				end else begin
					shot_next = shot_reg - PW'(1);
				end
			end
			SCS_DONE: begin
				// Further command presses fall through here unanswered
				if (arm_req) begin
					state_next = SCS_ARMED;
					lock_next  = 1'b0;
					done_next  = 1'b0;
				end
			end
			default: begin
				// Unused code: fall back to armed with nothing pending
				state_next = SCS_ARMED;
				lock_next  = 1'b0;
				done_next  = 1'b0;
			end
		endcase
		if (state_reg == SCS_ARMED && arm_req && !cmd_req) begin
			lock_next = 1'b0;
			done_next = 1'b0;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg    <= SCS_ARMED;
			lock_reg     <= 1'b0;
			done_reg     <= 1'b0;
			shot_reg     <= '0;
			held_sel_reg <= '0;
		end else begin
			state_reg    <= state_next;
			lock_reg     <= lock_next;
			done_reg     <= done_next;
			shot_reg     <= shot_next;
			held_sel_reg <= held_sel_next;
		end
	end

	// Output stage, every pin from its own flop
	assign chain.run = run_reg;
	always_comb begin
		// Lamps follow the next state so they switch with the relay
		relay_next = (state_next == SCS_PULSE);
		line_next  = relay_next ? line_decode(held_sel_next) : '0;
		rlamp_next = !lock_next;
		clamp_next = done_next;
		elec_next  = panel.elec_level;
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			relay_reg <= 1'b0;
			line_reg  <= '0;
			rlamp_reg <= 1'b1;
			clamp_reg <= 1'b0;
			elec_reg  <= 1'b0;
			tout_reg  <= '0;
			cal_reg   <= 1'b0;
		end else begin
			relay_reg <= relay_next;
			line_reg  <= line_next;
			rlamp_reg <= rlamp_next;
			clamp_reg <= clamp_next;
			elec_reg  <= elec_next;
			tout_reg  <= chain.stage;
			cal_reg   <= chain.cal;
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign command_line   = line_reg;
	assign command_relay  = relay_reg;
	assign reset_lamp     = rlamp_reg;
	assign command_lamp   = clamp_reg;
	assign electronics_on = elec_reg;
	assign timing_out     = tout_reg;
	assign cal_clock      = cal_reg;
endmodule : scs_command_sim
`default_nettype wire

// File: verification/scs_asserts.sv
// Checker for the command sequencer, lamps, bus answer and timing outputs
`default_nettype none
module scs_asserts
	import scs_pkg::*;
#(
	parameter int unsigned PULSE_CYC = 20
) (
	input wire logic                           clock,
	input wire logic                           reset,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pready,
	input wire logic [scs_pkg::CMD_LINES-1:0]  command_line,
	input wire logic                           command_relay,
	input wire logic                           reset_lamp,
	input wire logic                           command_lamp,
	input wire logic [scs_pkg::DIV_STAGES-1:0] timing_out
);
	int unsigned hi_reg;
	int unsigned hi_next;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Length of the current relay pulse, too long for a repetition
	always_comb hi_next = command_relay ? hi_reg + 1 : 0;
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			hi_reg <= 0;
		else
			hi_reg <= hi_next;
	end
	a_pulse_one_line: assert property (command_relay |-> $onehot(command_line))
		else $error("pulse not on a single line");
	a_relay_to_line: assert property ((command_line != '0) == command_relay)
		else $error("line and relay disagree");
	a_armed_lamps: assert property (reset_lamp |-> !command_lamp && !command_relay)
		else $error("armed lamps wrong");
	a_pulse_width: assert property ($fell(command_relay) |-> hi_reg == PULSE_CYC)
		else $error("pulse width wrong");
	a_pulse_cap: assert property (command_relay |-> hi_reg < PULSE_CYC)
		else $error("pulse too long");
	a_done_lamp: assert property ($fell(command_relay) |-> command_lamp && !reset_lamp)
		else $error("completion lamp not lit");
	a_start_armed: assert property ($rose(command_relay) |-> $past(reset_lamp) && !reset_lamp)
		else $error("pulse without arming");
	a_lock_hold: assert property (command_lamp |=> !$rose(command_relay))
		else $error("second pulse after completion");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no answer in first access cycle");
	a_stagger_edges: assert property ($countones(timing_out ^ $past(timing_out)) <= 1)
		else $error("timing outputs changed together");
endmodule : scs_asserts

bind scs_command_sim scs_asserts #(.PULSE_CYC(PULSE_CYC)) i_scs_asserts (.clock, .reset,
	.psel, .penable, .pready, .command_line, .command_relay, .reset_lamp, .command_lamp,
	.timing_out);
`default_nettype wire

// File: verification/scs_instrument.sv
// Instrument model on the command lines: records each received pulse
`default_nettype none
module scs_instrument
	import scs_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          reset,
	input  wire logic [scs_pkg::CMD_LINES-1:0] command_line,
	output var  int unsigned                   pulses,
	output var  logic [scs_pkg::CMD_LINES-1:0] last_line,
	output var  int unsigned                   last_width
);
	int unsigned width;
	// Width counted on the line itself, not on the relay
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pulses <= 0;
			last_line <= '0;
			last_width <= 0;
			width <= 0;
		end else if (command_line != '0) begin
			width <= width + 1;
			last_line <= command_line;
		end else if (width != 0) begin
			pulses <= pulses + 1;
			last_width <= width;
			width <= 0;
		end
	end
endmodule : scs_instrument
`default_nettype wire

// File: verification/scs_command_sim_tb_top.sv
// Self-checking bench for the command and clock simulator
`default_nettype none
module scs_command_sim_tb_top
	import scs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PC = 20;
	localparam int unsigned MC = 40;
	logic              clock = 0;
	logic              reset = 1;
	logic              arm_button = 0;
	logic              command_button = 0;
	logic              electronics_switch = 0;
	logic [SEL_W-1:0]  command_select = '0;
	logic              psel = 0;
	logic              penable = 0;
	logic              pwrite = 0;
	logic [11:0]       paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [7:0]        command_line;
	logic              command_relay;
	logic              reset_lamp;
	logic              command_lamp;
	logic              electronics_on;
	logic [8:0]        timing_out;
	logic              cal_clock;
	int unsigned       pulses;
	logic [7:0]        last_line;
	int unsigned       last_width;
	logic [31:0]       rd;
	logic              er;
	int                fail_count = 0;
	int                samples_checked = 0;
	// Short counts keep the run small; all figures derive from them
	scs_command_sim #(.PULSE_CYC(PC), .MASTER_CYC_P(MC), .DEB_CYC(4), .DELAY_CYC_P(2))
	i_scs_command_sim (.clock, .reset, .arm_button, .command_button, .electronics_switch,
		.command_select, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .command_line, .command_relay, .reset_lamp, .command_lamp,
		.electronics_on, .timing_out, .cal_clock);
	scs_instrument i_scs_instrument (.clock, .reset, .command_line, .pulses, .last_line,
		.last_width);
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic bail();
		fail_count++;
		$display("[FAIL] wait limit expected answer seen none");
		complete_run();
	endtask : bail
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
	endtask : cycles
	task automatic drive(input logic a, input logic c, input int n);
		arm_button <= a;
		command_button <= c;
		cycles(n);
	endtask : drive
	task automatic wait_relay(input logic lvl);
		int n;
		n = 0;
		while (command_relay !== lvl && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (command_relay !== lvl)
			bail();
	endtask : wait_relay
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1)
			bail();
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : apb
	task automatic t_reset_state();
		check("reset_lamp", reset_lamp, 1'h1);
		check("command_lamp", command_lamp, 1'h0);
		apb(0, OFS_CTRL, 32'h0);
		check("ctrl", rd, 32'h4);
		check("ctrl err", er, 1'h0);
		apb(0, 12'h0FC, 32'h0);
		check("slverr", er, 1'h1);
		check("unmapped", rd, 32'h0);
		$display("test reset_state done");
	endtask : t_reset_state
	task automatic t_button_pulse();
		command_select <= 3'h5;
		cycles(16);
		drive(0, 1, 1);
		wait_relay(1);
		check("line", command_line, 8'h20);
		check("reset_lamp", reset_lamp, 1'h0);
		drive(0, 0, 1);
		wait_relay(0);
		cycles(1);
		check("width", last_width, PC);
		check("lamp", command_lamp, 1'h1);
		apb(0, OFS_STATUS, 32'h0);
		check("status", rd[2:0], 3'h3);
		$display("test button_pulse done");
	endtask : t_button_pulse
	task automatic t_lockout();
		int unsigned p;
		p = pulses;
		drive(0, 1, 16);
		drive(0, 0, 40);
		check("pulses", pulses, p);
		// Bounce shorter than the debounce window must not re-arm
		// Period 3 against a sample period of 4, so no lucky alias
		repeat (4) begin
			drive(1, 0, 1);
			drive(0, 0, 2);
		end
		check("bounce", reset_lamp, 1'h0);
		drive(1, 0, 16);
		drive(0, 0, 16);
		check("armed", reset_lamp, 1'h1);
		check("cleared", command_lamp, 1'h0);
		$display("test lockout done");
	endtask : t_lockout
	task automatic t_all_lines();
		for (int s = 0; s < 8; s++) begin
			command_select <= s[2:0];
			cycles(16);
			apb(1, OFS_CTRL, 32'h5);
			apb(1, OFS_CTRL, 32'h6);
			wait_relay(1);
			wait_relay(0);
			cycles(1);
			check("soft line", last_line, 8'h1 << s);
			check("soft width", last_width, PC);
			apb(0, OFS_SELECT, 32'h0);
			check("latched", rd[6:4], s[2:0]);
			check("live", rd[2:0], s[2:0]);
		end
		$display("test all_lines done");
	endtask : t_all_lines
	task automatic t_electronics();
		electronics_switch <= 1'h1;
		cycles(16);
		check("elec on", electronics_on, 1'h1);
		apb(0, OFS_STATUS, 32'h0);
		check("elec bit", rd[3], 1'h1);
		electronics_switch <= 1'h0;
		cycles(16);
		check("elec off", electronics_on, 1'h0);
		$display("test electronics done");
	endtask : t_electronics
	task automatic t_clock_chain();
		int t0;
		int t8;
		int ch;
		logic [8:0] pv;
		t0 = 0;
		t8 = 0;
		ch = 0;
		// One full 512-tick period, so the count holds at any phase
		repeat (512 * MC) begin
			pv = timing_out;
			@(posedge clock);
			t0 += (timing_out[0] != pv[0]);
			t8 += (timing_out[8] != pv[8]);
			ch += cal_clock;
		end
		check("stage0 edges", t0, 32'h200);
		check("stage8 edges", t8, 32'h2);
		check("cal high", ch, 64 * MC);
		// Stopped master clock: an odd tick count would flip stage 0
		apb(1, OFS_CTRL, 32'h0);
		cycles(MC);
		pv = timing_out;
		cycles(3 * MC);
		check("held stages", timing_out, pv);
		apb(0, OFS_CTRL, 32'h0);
		check("run off", rd, 32'h0);
		apb(1, OFS_CTRL, 32'h4);
		$display("test clock_chain done");
	endtask : t_clock_chain
	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		t_reset_state();
		t_button_pulse();
		t_lockout();
		t_all_lines();
		t_electronics();
		t_clock_chain();
		complete_run();
	end
endmodule : scs_command_sim_tb_top
`default_nettype wire
